/* File: test/ddcc_checker.sv */
// Port-level assertions of the capture/compare unit
`timescale 1ns/1ps
module ddcc_checker (
   input wire logic                    MCLK,
   input wire logic                    SRST,
   input wire ddcc_pkg::ddcc_axi_req_t S_AXI_REQ,
   input wire ddcc_pkg::ddcc_axi_rsp_t S_AXI_RSP,
   input wire logic                    MAIN_CHANNEL_OUTPUT,
   input wire logic                    MAIN_OUTPUT_EN_N,
   input wire logic                    MULTI_CHANNEL_OUTPUT,
   input wire logic                    MULTI_OUTPUT_EN_N,
   input wire logic                    MAIN_DMA_REQ,
   input wire logic                    MULTI_DMA_REQ
);
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (SRST);
   write_walk_a: assert property (S_AXI_REQ.awvalid && S_AXI_RSP.awready && S_AXI_REQ.wvalid && S_AXI_RSP.wready
      |=> !S_AXI_RSP.awready && !S_AXI_RSP.wready ##1 S_AXI_RSP.bvalid) else $error("write walk broken");
   b_ready_a: assert property ($rose(S_AXI_RSP.bvalid) |-> S_AXI_RSP.awready && S_AXI_RSP.wready)
      else $error("readies not back");
   read_walk_a: assert property (S_AXI_REQ.arvalid && S_AXI_RSP.arready |=> S_AXI_RSP.rvalid && !S_AXI_RSP.arready)
      else $error("read walk broken");
   r_refuse_a: assert property (S_AXI_RSP.rvalid |-> !S_AXI_RSP.arready) else $error("read not refused");
   main_off_a: assert property (MAIN_OUTPUT_EN_N |-> !MAIN_CHANNEL_OUTPUT) else $error("main off");
   multi_off_a: assert property (MULTI_OUTPUT_EN_N |-> !MULTI_CHANNEL_OUTPUT) else $error("multi off");
   main_dma_a: assert property (MAIN_DMA_REQ |=> !MAIN_DMA_REQ) else $error("main dma long");
   multi_dma_a: assert property (MULTI_DMA_REQ |=> !MULTI_DMA_REQ) else $error("multi dma long");
endmodule
bind ddcc_top ddcc_checker u_chk (.MCLK(MCLK), .SRST(SRST), .S_AXI_REQ(S_AXI_REQ), .S_AXI_RSP(S_AXI_RSP),
   .MAIN_CHANNEL_OUTPUT(MAIN_CHANNEL_OUTPUT), .MAIN_OUTPUT_EN_N(MAIN_OUTPUT_EN_N),
   .MULTI_CHANNEL_OUTPUT(MULTI_CHANNEL_OUTPUT), .MULTI_OUTPUT_EN_N(MULTI_OUTPUT_EN_N),
   .MAIN_DMA_REQ(MAIN_DMA_REQ), .MULTI_DMA_REQ(MULTI_DMA_REQ));

/* File: test/ddcc_pin_model.sv */
// Pin-side model driving one channel input with a short pulse
`timescale 1ns/1ps
module ddcc_pin_model (
   input  wire logic clk,
   input  wire logic fire,
   output logic      pin
);
   logic [2:0] n_q;
   initial n_q = 3'h0;
   // Pulse outlasts sync and filter so the edge is seen
   always @(posedge clk) begin
      n_q <= fire ? 3'h5 : (n_q != 3'h0 ? n_q - 3'h1 : 3'h0);
   end
   assign pin = (n_q != 3'h0);
endmodule

/* File: test/testbench.sv */
// Self-checking bench of the capture/compare unit
`timescale 1ns/1ps
module testbench;
   import ddcc_pkg::*;
   logic          MCLK, SRST, tick, fire, pin, mo;
   logic [15:0]   cnt;
   logic [2:0]    ev;
   logic [31:0]   rd, seed;
   logic [1:0]    rr;
   ddcc_axi_req_t req;
   ddcc_axi_rsp_t rsp;
   int            n_errors = 0, cmp_count = 0, k;
   ddcc_pin_model pm (.clk(MCLK), .fire(fire), .pin(pin));
   ddcc_top uut (.MCLK(MCLK), .SRST(SRST), .S_AXI_REQ(req), .S_AXI_RSP(rsp), .COUNTER_VALUE(cnt),
      .COUNTER_TICK(tick), .UPDATE_EVENT(1'b0), .INTERNAL_TRIGGER(1'b0), .MAIN_CHANNEL_INPUT(pin),
      .MULTI_CHANNEL_INPUT(1'b0), .MAIN_CHANNEL_OUTPUT(), .MAIN_OUTPUT_EN_N(), .MULTI_CHANNEL_OUTPUT(mo),
      .MULTI_OUTPUT_EN_N(), .MAIN_IRQ(ev[0]), .MULTI_IRQ(ev[2]), .MAIN_DMA_REQ(ev[1]), .MULTI_DMA_REQ());
   initial begin
      MCLK = 0;
      forever #5 MCLK = ~MCLK;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      return s ^ (s << 5);
   endfunction
   // Expected multi prepare bit of the status word for a compare action
   function automatic logic [31:0] prep_exp(input int a, input logic [15:0] c, input logic [15:0] v);
      case (a)
         5: return 32'h20;
         6: return (c < v) ? 32'h20 : 32'h0;
         7: return (c < v) ? 32'h0 : 32'h20;
         default: return 32'h0;
      endcase
   endfunction
   task test_done;
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         n_errors++;
         $display("wrong value at %0t: got %h exp %h", $time, s, e);
      end
   endtask
   // Readies are sampled in the active region, before this edge's updates land
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      if (w) begin
         req.awaddr <= a;
         req.wdata <= d;
         req.awvalid <= 1'b1;
         req.wvalid <= 1'b1;
      end else begin
         req.araddr <= a;
         req.arvalid <= 1'b1;
      end
      for (i = 0; i < 20; i++) begin
         @(posedge MCLK);
         // Lower each valid only once, so the next call may raise it at this edge
         if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
         if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
         if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
         if (w ? rsp.bvalid : rsp.rvalid) break;
      end
      rd = rsp.rdata;
      rr = w ? rsp.bresp : rsp.rresp;
      if (i == 20) begin
         n_errors++;
         test_done;
      end
   endtask
   task wt(input int n);
      int i;
      for (i = 0; i < 40; i++) begin
         @(posedge MCLK);
         if (ev[n] === 1'b1) break;
      end
      if (i == 40) begin
         n_errors++;
         test_done;
      end
   endtask
   task edge_in;
      seed = xs(seed);
      cnt <= seed[15:0];
      fire <= 1'b1;
      @(posedge MCLK);
      fire <= 1'b0;
   endtask
   initial begin
      SRST = 1;
      req = '0;
      req.wstrb = 4'hf;
      req.bready = 1;
      req.rready = 1;
      tick = 0;
      fire = 0;
      cnt = 0;
      seed = 32'd68;
      repeat (3) @(posedge MCLK);
      SRST <= 0;
      @(posedge MCLK);
      xfer(0, 8'h00, 0);
      chk(rd, 0);
      xfer(0, 8'h1c, 0);
      chk({30'h0, rr}, 32'h2);
      $display("reset and map test done");
      xfer(1, 8'h00, 32'hc);
      xfer(1, 8'h04, 32'h40c);
      edge_in;
      wt(0);
      xfer(0, 8'h14, 0);
      chk(rd, {16'h0, cnt});
      xfer(0, 8'h0c, 0);
      chk(rd & 32'h5, 32'h1);
      xfer(1, 8'h14, {16'h0, ~cnt});
      xfer(0, 8'h14, 0);
      chk(rd, {16'h0, cnt});
      xfer(1, 8'h04, 32'h41c);
      edge_in;
      repeat (12) @(posedge MCLK);
      xfer(0, 8'h0c, 0);
      chk(rd & 32'h5, 32'h1);
      edge_in;
      wt(1);
      xfer(0, 8'h14, 0);
      chk(rd, {16'h0, cnt});
      xfer(0, 8'h0c, 0);
      chk(rd & 32'h5, 32'h5);
      $display("capture test done");
      seed = xs(seed);
      xfer(1, 8'h18, {16'h0, seed[31:16]});
      xfer(1, 8'h08, 32'h400c);
      cnt <= seed[31:16];
      tick <= 1'b1;
      @(posedge MCLK);
      tick <= 1'b0;
      wt(2);
      chk({31'h0, mo}, 32'h1);
      xfer(0, 8'h0c, 0);
      chk(rd & 32'h22, 32'h22);
      // Forced levels, then PWM duty against the multi compare value
      for (k = 4; k < 8; k++) begin
         xfer(1, 8'h08, {14'h0, k[3:0], 14'h0});
         cnt <= seed[15:0] ^ {k[3:0], 12'h0};
         tick <= 1'b1;
         @(posedge MCLK);
         tick <= 1'b0;
         xfer(0, 8'h0c, 0);
         chk(rd & 32'h20, prep_exp(k, cnt, seed[31:16]));
      end
      $display("compare test done");
      xfer(1, 8'h0c, 32'hf);
      xfer(1, 8'h10, 32'h1);
      xfer(0, 8'h0c, 0);
      chk(rd & 32'h1, 32'h1);
      $display("soft event test done");
      test_done;
   end
endmodule

/* File: verilog/ddcc_cmp_prep.sv */
// Compare match detection and prepare signal of one channel
`timescale 1ns/1ps
module ddcc_cmp_prep #(
   parameter int CW = 16
) (
   input  wire logic          clk,
   input  wire logic          srst,
   input  wire logic [CW-1:0] cnt,
   input  wire logic          tick,
   input  wire logic          update,
   input  wire logic [CW-1:0] cv,
   input  wire logic [3:0]    action,
   input  wire logic          shadow_en,
   output logic               prep,
   output logic               match
);
   import ddcc_pkg::*;
   logic [CW-1:0] act_cv_q;
   logic [CW-1:0] act_cv_d;
   logic          prep_d;
   logic          match_d;

   always_comb begin
      act_cv_d = act_cv_q;
      if (!shadow_en || update) begin
         act_cv_d = cv;
      end
      match_d = tick && (cnt == act_cv_q);
      prep_d  = prep;
      case (ddcc_action_t'(action))
         ACT_SET:      if (match_d) prep_d = 1'b1;
         ACT_CLR:      if (match_d) prep_d = 1'b0;
         ACT_TOG:      if (match_d) prep_d = ~prep;
         ACT_FORCE_LO: prep_d = 1'b0;
         ACT_FORCE_HI: prep_d = 1'b1;
         // Counter wraps at auto-reload, so cv above it keeps cnt < cv true
         ACT_PWM0:     if (tick) prep_d = (cnt < act_cv_q);
         ACT_PWM1:     if (tick) prep_d = !(cnt < act_cv_q);
         default:      prep_d = prep;
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         act_cv_q <= '0;
         prep     <= 1'b0;
         match    <= 1'b0;
      end else begin
         act_cv_q <= act_cv_d;
         prep     <= prep_d;
         match    <= match_d;
      end
   end
endmodule

/* File: verilog/ddcc_in_filter.sv */
// Input synchroniser and digital filter for one channel input
`timescale 1ns/1ps
module ddcc_in_filter (
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic       pin,
   input  wire logic [3:0] setting,
   output logic            level
);
   import ddcc_pkg::*;
   logic       meta_q;
   logic       sync_q;
   logic       level_d;
   logic [3:0] run_q;
   logic [3:0] run_d;

   // New level accepted after it differs for setting+1 samples
   always_comb begin
      level_d = level;
      run_d   = 4'h0;
      if (sync_q != level) begin
         if (run_q >= setting) begin
            level_d = sync_q;
         end else begin
            run_d = run_q + 4'h1;
         end
      end
   end

   always_ff @(posedge clk) begin
      meta_q <= pin;
      sync_q <= meta_q;
      if (srst) begin
         level <= 1'b0;
         run_q <= 4'h0;
      end else begin
         level <= level_d;
         run_q <= run_d;
      end
   end
endmodule

/* File: verilog/ddcc_pkg.sv */
// Types shared by the capture/compare unit
package ddcc_pkg;
   typedef struct packed {
      logic [7:0]  awaddr;
      logic        awvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        wvalid;
      logic        bready;
      logic [7:0]  araddr;
      logic        arvalid;
      logic        rready;
   } ddcc_axi_req_t;
   typedef struct packed {
      logic        awready;
      logic        wready;
      logic [1:0]  bresp;
      logic        bvalid;
      logic        arready;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        rvalid;
   } ddcc_axi_rsp_t;
   typedef enum logic [3:0] {
      ACT_HOLD = 4'h0, ACT_SET = 4'h1, ACT_CLR = 4'h2, ACT_TOG = 4'h3,
      ACT_FORCE_LO = 4'h4, ACT_FORCE_HI = 4'h5, ACT_PWM0 = 4'h6, ACT_PWM1 = 4'h7
   } ddcc_action_t;
   typedef enum logic [2:0] {
      SRC_OUTPUT = 3'h0, SRC_OWN = 3'h1, SRC_OTHER = 3'h2, SRC_TRIG = 3'h3
   } ddcc_source_t;
   typedef struct packed {
      logic [3:0] compare_action;
      logic       compare_shadow_enable;
      logic [2:0] source_select;
      logic [3:0] input_filter;
      logic [1:0] capture_prescale;
      logic       irq_enable;
      logic       dma_enable;
      logic [1:0] edge_select;
   } ddcc_chcfg_t;
   typedef struct packed {
      logic [7:0] dead_time_setting;
      logic       idle_offstate_select;
      logic       run_offstate_select;
      logic       primary_output_enable;
      logic [1:0] multi_polarity;
      logic       main_polarity;
      logic [1:0] channel_enable;
      logic [1:0] pair_mode_select;
   } ddcc_ctrl_t;
endpackage

/* File: verilog/ddcc_regs.svh */
// Register offsets, widths and reset values of the capture/compare unit
`ifndef DDCC_REGS_SVH
`define DDCC_REGS_SVH
`define DDCC_OFS_CTRL      8'h00
`define DDCC_OFS_MAIN_CFG  8'h04
`define DDCC_OFS_MULTI_CFG 8'h08
`define DDCC_OFS_STATUS    8'h0c
`define DDCC_OFS_SOFT      8'h10
`define DDCC_OFS_MAIN_CV   8'h14
`define DDCC_OFS_MULTI_CV  8'h18
`define DDCC_IDX_CTRL      3'h0
`define DDCC_IDX_MAIN_CFG  3'h1
`define DDCC_IDX_MULTI_CFG 3'h2
`define DDCC_IDX_STATUS    3'h3
`define DDCC_IDX_SOFT      3'h4
`define DDCC_IDX_MAIN_CV   3'h5
`define DDCC_IDX_MULTI_CV  3'h6
`define DDCC_CTRL_W        18
`define DDCC_CFG_W         18
`define DDCC_CTRL_RST      18'h00000
`define DDCC_CFG_RST       18'h00000
`define DDCC_PAIR_INDEP    2'h0
`define DDCC_PAIR_COMPL    2'h3
`define DDCC_RESP_OKAY     2'h0
`define DDCC_RESP_SLVERR   2'h2
`endif

/* File: verilog/ddcc_top.sv */
// Two-channel capture/compare unit with AXI4-Lite register slave
//
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "ddcc_regs.svh"
// Operation
// - Pair mode 00 lets main and multi channels capture independently.
// - Capture edge copies counter to value register, sets flag, raises enabled interrupt.
// - Inputs are synchronised, then filtered per channel filter setting.
// - Rising or falling filtered edge chosen by polarity or multi edge field.
// - Source is own input, other input or trigger; non-zero selects input mode.
// - Software writes to value register ignored while in input mode.
// - Prescaler turns a programmable number of edges into one capture.
// - Capture while flag still set also sets over-capture flag.
// - Capture drives interrupt and DMA request only when enabled.
// - Software event bit produces channel event without edge or match.
// - Capture only happens once the channel enable bit is set.
// - Independent main output is prepare signal XOR polarity, gated by enable.
// - Independent multi output uses its own prepare, polarity and enable.
// - Pair mode 11 makes multi output the inverse, with off-states and dead time.
// - Compare match sets, clears or toggles output per compare action.
// - Compare match sets flag, enabled interrupt and enabled DMA request.
// - Compare value has shadow enable and stays writable while counting.
// - Compare action 0110 is PWM mode 0, 0111 is PWM mode 1.
// - PWM period follows auto-reload, duty follows compare value.
// - Compare value above auto-reload: PWM0 always active, PWM1 always inactive.
// - Actions 0..3 hold, set high, set low or toggle on match.
// - Actions 4 and 5 force prepare inactive or active regardless of match.
module ddcc_top #(
   parameter int CW = 16
) (
   input  wire logic                    MCLK,
   input  wire logic                    SRST,
   input  wire ddcc_pkg::ddcc_axi_req_t S_AXI_REQ,
   output ddcc_pkg::ddcc_axi_rsp_t      S_AXI_RSP,
   input  wire logic [CW-1:0]           COUNTER_VALUE,
   input  wire logic                    COUNTER_TICK,
   input  wire logic                    UPDATE_EVENT,
   input  wire logic                    INTERNAL_TRIGGER,
   input  wire logic                    MAIN_CHANNEL_INPUT,
   input  wire logic                    MULTI_CHANNEL_INPUT,
   output logic                         MAIN_CHANNEL_OUTPUT,
   output logic                         MAIN_OUTPUT_EN_N,
   output logic                         MULTI_CHANNEL_OUTPUT,
   output logic                         MULTI_OUTPUT_EN_N,
   output logic                         MAIN_IRQ,
   output logic                         MULTI_IRQ,
   output logic                         MAIN_DMA_REQ,
   output logic                         MULTI_DMA_REQ
);
   import ddcc_pkg::*;
   localparam int NCH = 2;

   // Returns {hit, index} for a byte address
   function automatic logic [3:0] decode(input logic [7:0] addr);
      logic [3:0] r;
      r = {1'b0, addr[4:2]};
      if (addr[7:5] == 3'h0 && addr[4:2] != 3'h7) begin
         r[3] = 1'b1;
      end
      return r;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) r[i*8 +: 8] = nw[i*8 +: 8];
      end
      return r;
   endfunction

   // Bus slave state
   logic          awready_q, awready_d;
   logic          wready_q, wready_d;
   logic          bvalid_q, bvalid_d;
   logic [1:0]    bresp_q, bresp_d;
   logic          arready_q, arready_d;
   logic          rvalid_q, rvalid_d;
   logic [1:0]    rresp_q, rresp_d;
   logic [31:0]   rdata_q, rdata_d;
   logic [7:0]    awaddr_q, awaddr_d;
   logic [31:0]   wdata_q, wdata_d;
   logic [3:0]    wstrb_q, wstrb_d;
   logic          wr_go;
   logic [3:0]    wr_dec;
   logic [3:0]    rd_dec;

   // Register state
   ddcc_ctrl_t    ctrl_q, ctrl_d;
   ddcc_chcfg_t   cfg_q[NCH];
   ddcc_chcfg_t   cfg_d[NCH];
   logic [CW-1:0] cv_q[NCH];
   logic [CW-1:0] cv_d[NCH];
   logic [1:0]    flag_q, flag_d;
   logic [1:0]    ovc_q, ovc_d;
   logic [1:0]    soft_q, soft_d;

   // Channel datapath
   logic [1:0]    filt;
   logic [1:0]    prep;
   logic [1:0]    match;
   logic [1:0]    cap;
   logic [1:0]    in_mode;
   logic [1:0]    evt;

   assign S_AXI_RSP.awready = awready_q;
   assign S_AXI_RSP.wready  = wready_q;
   assign S_AXI_RSP.bvalid  = bvalid_q;
   assign S_AXI_RSP.bresp   = bresp_q;
   assign S_AXI_RSP.arready = arready_q;
   assign S_AXI_RSP.rvalid  = rvalid_q;
   assign S_AXI_RSP.rresp   = rresp_q;
   assign S_AXI_RSP.rdata   = rdata_q;

   assign wr_go  = !awready_q && !wready_q && !bvalid_q;
   assign wr_dec = decode(awaddr_q);
   assign rd_dec = decode(S_AXI_REQ.araddr);

   // Address and data are taken in either order; response after both
   always_comb begin
      awready_d = awready_q;
      wready_d  = wready_q;
      bvalid_d  = bvalid_q;
      bresp_d   = bresp_q;
      awaddr_d  = awaddr_q;
      wdata_d   = wdata_q;
      wstrb_d   = wstrb_q;
      arready_d = arready_q;
      rvalid_d  = rvalid_q;
      rresp_d   = rresp_q;
      rdata_d   = rdata_q;
      if (awready_q && S_AXI_REQ.awvalid) begin
         awready_d = 1'b0;
         awaddr_d  = S_AXI_REQ.awaddr;
      end
      if (wready_q && S_AXI_REQ.wvalid) begin
         wready_d = 1'b0;
         wdata_d  = S_AXI_REQ.wdata;
         wstrb_d  = S_AXI_REQ.wstrb;
      end
      if (wr_go) begin
         bvalid_d  = 1'b1;
         bresp_d   = wr_dec[3] ? `DDCC_RESP_OKAY : `DDCC_RESP_SLVERR;
         awready_d = 1'b1;
         wready_d  = 1'b1;
      end
      if (bvalid_q && S_AXI_REQ.bready) begin
         bvalid_d = 1'b0;
      end
      if (arready_q && S_AXI_REQ.arvalid) begin
         arready_d = 1'b0;
         rvalid_d  = 1'b1;
         rresp_d   = rd_dec[3] ? `DDCC_RESP_OKAY : `DDCC_RESP_SLVERR;
         case (rd_dec)
            {1'b1, `DDCC_IDX_CTRL}:      rdata_d = 32'(ctrl_q);
            {1'b1, `DDCC_IDX_MAIN_CFG}:  rdata_d = 32'(cfg_q[0]);
            {1'b1, `DDCC_IDX_MULTI_CFG}: rdata_d = 32'(cfg_q[1]);
            {1'b1, `DDCC_IDX_STATUS}:    rdata_d = {24'h0, filt, prep, ovc_q, flag_q};
            {1'b1, `DDCC_IDX_MAIN_CV}:   rdata_d = 32'(cv_q[0]);
            {1'b1, `DDCC_IDX_MULTI_CV}:  rdata_d = 32'(cv_q[1]);
            default:                     rdata_d = 32'h0;
         endcase
      end
      if (rvalid_q && S_AXI_REQ.rready) begin
         rvalid_d  = 1'b0;
         arready_d = 1'b1;
      end
   end

   always_ff @(posedge MCLK) begin
      if (SRST) begin
         awready_q <= 1'b1;
         wready_q  <= 1'b1;
         bvalid_q  <= 1'b0;
         bresp_q   <= 2'h0;
         awaddr_q  <= 8'h00;
         wdata_q   <= 32'h0;
         wstrb_q   <= 4'h0;
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rresp_q   <= 2'h0;
         rdata_q   <= 32'h0;
      end else begin
         awready_q <= awready_d;
         wready_q  <= wready_d;
         bvalid_q  <= bvalid_d;
         bresp_q   <= bresp_d;
         awaddr_q  <= awaddr_d;
         wdata_q   <= wdata_d;
         wstrb_q   <= wstrb_d;
         arready_q <= arready_d;
         rvalid_q  <= rvalid_d;
         rresp_q   <= rresp_d;
         rdata_q   <= rdata_d;
      end
   end

   // Per-channel input stage, capture and compare
   for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
      logic       sel_sig;
      logic       sel_prev_q;
      logic       falling;
      logic       edge_hit;
      logic       armed;
      logic [2:0] psc_q, psc_d;

      ddcc_in_filter u_filt (
         .clk     (MCLK),
         .srst    (SRST),
         .pin     ((ch == 0) ? MAIN_CHANNEL_INPUT : MULTI_CHANNEL_INPUT),
         .setting (cfg_q[ch].input_filter),
         .level   (filt[ch])
      );

      ddcc_cmp_prep #(.CW(CW)) u_cmp (
         .clk       (MCLK),
         .srst      (SRST),
         .cnt       (COUNTER_VALUE),
         .tick      (COUNTER_TICK),
         .update    (UPDATE_EVENT),
         .cv        (cv_q[ch]),
         .action    (cfg_q[ch].compare_action),
         .shadow_en (cfg_q[ch].compare_shadow_enable),
         .prep      (prep[ch]),
         .match     (match[ch])
      );

      always_comb begin
         case (ddcc_source_t'(cfg_q[ch].source_select))
            SRC_OTHER: sel_sig = filt[1-ch];
            SRC_TRIG:  sel_sig = INTERNAL_TRIGGER;
            default:   sel_sig = filt[ch];
         endcase
      end

      assign in_mode[ch] = (cfg_q[ch].source_select != 3'h0);
      assign falling = (ch == 0) ? ctrl_q.main_polarity :
                       (cfg_q[1].edge_select[1] ? ctrl_q.multi_polarity[0] : cfg_q[1].edge_select[0]);
      assign edge_hit = falling ? (sel_prev_q && !sel_sig) : (!sel_prev_q && sel_sig);
      // Multi channel captures only in independent pairing
      assign armed = in_mode[ch] && ctrl_q.channel_enable[ch] &&
                     (ch == 0 || ctrl_q.pair_mode_select == `DDCC_PAIR_INDEP);

      // Prescaler: 1, 2, 4 or 8 edges per capture
      always_comb begin
         psc_d   = psc_q;
         cap[ch] = 1'b0;
         if (!armed) begin
            psc_d = 3'h0;
         end else if (edge_hit) begin
            if (psc_q == 3'((4'h1 << cfg_q[ch].capture_prescale) - 4'h1)) begin
               psc_d   = 3'h0;
               cap[ch] = 1'b1;
            end else begin
               psc_d = psc_q + 3'h1;
            end
         end
      end

      assign evt[ch] = cap[ch] || (match[ch] && !in_mode[ch]) || soft_q[ch];

      always_ff @(posedge MCLK) begin
         if (SRST) begin
            sel_prev_q <= 1'b0;
            psc_q      <= 3'h0;
         end else begin
            sel_prev_q <= sel_sig;
            psc_q      <= psc_d;
         end
      end
   end

   // Register file: software writes, then hardware events
   always_comb begin
      ctrl_d = ctrl_q;
      cfg_d  = cfg_q;
      cv_d   = cv_q;
      flag_d = flag_q;
      ovc_d  = ovc_q;
      soft_d = 2'h0;
      if (wr_go && wr_dec[3]) begin
         case (wr_dec[2:0])
            `DDCC_IDX_CTRL:      ctrl_d = ddcc_ctrl_t'(merge(32'(ctrl_q), wdata_q, wstrb_q));
            `DDCC_IDX_MAIN_CFG:  cfg_d[0] = ddcc_chcfg_t'(merge(32'(cfg_q[0]), wdata_q, wstrb_q));
            `DDCC_IDX_MULTI_CFG: cfg_d[1] = ddcc_chcfg_t'(merge(32'(cfg_q[1]), wdata_q, wstrb_q));
            `DDCC_IDX_STATUS: begin
               if (wstrb_q[0]) begin
                  flag_d = flag_q & ~wdata_q[1:0];
                  ovc_d  = ovc_q & ~wdata_q[3:2];
               end
            end
            `DDCC_IDX_SOFT: if (wstrb_q[0]) soft_d = wdata_q[1:0];
            `DDCC_IDX_MAIN_CV: begin
               if (!in_mode[0]) cv_d[0] = CW'(merge(32'(cv_q[0]), wdata_q, wstrb_q));
            end
            `DDCC_IDX_MULTI_CV: begin
               if (!in_mode[1]) cv_d[1] = CW'(merge(32'(cv_q[1]), wdata_q, wstrb_q));
            end
            default: ctrl_d = ctrl_q;
         endcase
      end
      // Hardware sets win over a same-cycle clear
      for (int i = 0; i < NCH; i++) begin
         if (cap[i]) begin
            cv_d[i] = COUNTER_VALUE;
            if (flag_q[i]) ovc_d[i] = 1'b1;
         end
         if (evt[i]) flag_d[i] = 1'b1;
      end
   end

   always_ff @(posedge MCLK) begin
      if (SRST) begin
         ctrl_q <= ddcc_ctrl_t'(`DDCC_CTRL_RST);
         for (int i = 0; i < NCH; i++) begin
            cfg_q[i] <= ddcc_chcfg_t'(`DDCC_CFG_RST);
            cv_q[i]  <= '0;
         end
         flag_q <= 2'h0;
         ovc_q  <= 2'h0;
         soft_q <= 2'h0;
      end else begin
         ctrl_q <= ctrl_d;
         cfg_q  <= cfg_d;
         cv_q   <= cv_d;
         flag_q <= flag_d;
         ovc_q  <= ovc_d;
         soft_q <= soft_d;
      end
   end

   // Output stage with dead time in complementary pairing
   logic       prep0_prev_q;
   logic [7:0] dt_q, dt_d;
   logic       dt_on;
   logic       main_raw, multi_raw;
   logic       main_o_d, main_oen_d, multi_o_d, multi_oen_d;
   logic [1:0] irq_d, dma_d;

   assign dt_on = ctrl_q.primary_output_enable && (ctrl_q.channel_enable == 2'h3);

   always_comb begin
      dt_d = dt_q;
      if (prep[0] != prep0_prev_q) begin
         dt_d = ctrl_q.dead_time_setting;
      end else if (dt_q != 8'h0) begin
         dt_d = dt_q - 8'h1;
      end
      // Both sides held inactive while the dead time runs
      main_raw  = prep[0] && (!dt_on || dt_d == 8'h0);
      multi_raw = !prep[0] && (!dt_on || dt_d == 8'h0);
      main_o_d    = 1'b0;
      main_oen_d  = 1'b1;
      multi_o_d   = 1'b0;
      multi_oen_d = 1'b1;
      if (ctrl_q.pair_mode_select == `DDCC_PAIR_COMPL) begin
         if (!ctrl_q.primary_output_enable) begin
            if (ctrl_q.idle_offstate_select || ctrl_q.channel_enable != 2'h0) begin
               main_o_d    = ctrl_q.main_polarity;
               multi_o_d   = ctrl_q.multi_polarity[0];
               main_oen_d  = 1'b0;
               multi_oen_d = 1'b0;
            end
         end else begin
            if (ctrl_q.channel_enable[0] || ctrl_q.run_offstate_select) begin
               main_o_d   = ctrl_q.channel_enable[0] ? (main_raw ^ ctrl_q.main_polarity) : ctrl_q.main_polarity;
               main_oen_d = 1'b0;
            end
            if (ctrl_q.channel_enable[1] || ctrl_q.run_offstate_select) begin
               multi_o_d   = ctrl_q.channel_enable[1] ? (multi_raw ^ ctrl_q.multi_polarity[0]) :
                                                        ctrl_q.multi_polarity[0];
               multi_oen_d = 1'b0;
            end
         end
      end else begin
         if (ctrl_q.channel_enable[0]) begin
            main_o_d   = prep[0] ^ ctrl_q.main_polarity;
            main_oen_d = 1'b0;
         end
         if (ctrl_q.channel_enable[1]) begin
            multi_o_d   = prep[1] ^ ctrl_q.multi_polarity[0];
            multi_oen_d = 1'b0;
         end
      end
      for (int i = 0; i < NCH; i++) begin
         irq_d[i] = flag_d[i] && cfg_q[i].irq_enable;
         dma_d[i] = evt[i] && cfg_q[i].dma_enable;
      end
   end

   always_ff @(posedge MCLK) begin
      if (SRST) begin
         prep0_prev_q         <= 1'b0;
         dt_q                 <= 8'h0;
         MAIN_CHANNEL_OUTPUT  <= 1'b0;
         MAIN_OUTPUT_EN_N     <= 1'b1;
         MULTI_CHANNEL_OUTPUT <= 1'b0;
         MULTI_OUTPUT_EN_N    <= 1'b1;
         MAIN_IRQ             <= 1'b0;
         MULTI_IRQ            <= 1'b0;
         MAIN_DMA_REQ         <= 1'b0;
         MULTI_DMA_REQ        <= 1'b0;
      end else begin
         prep0_prev_q         <= prep[0];
         dt_q                 <= dt_d;
         MAIN_CHANNEL_OUTPUT  <= main_o_d;
         MAIN_OUTPUT_EN_N     <= main_oen_d;
         MULTI_CHANNEL_OUTPUT <= multi_o_d;
         MULTI_OUTPUT_EN_N    <= multi_oen_d;
         MAIN_IRQ             <= irq_d[0];
         MULTI_IRQ            <= irq_d[1];
         MAIN_DMA_REQ         <= dma_d[0];
         MULTI_DMA_REQ        <= dma_d[1];
      end
   end
endmodule
